// >>> verilog/mpg_cfg.svh
// Constants for the multidrop port address gate
`ifndef MPG_CFG_SVH
`define MPG_CFG_SVH
`define MPG_OFF_CTRL      6'h00
`define MPG_OFF_ADDR      6'h04
`define MPG_OFF_SETTLE    6'h08
`define MPG_OFF_TIMEOUT   6'h0C
`define MPG_OFF_STATUS    6'h10
`define MPG_OFF_RXDATA    6'h14
`define MPG_OFF_TXDATA    6'h18
`define MPG_PFX_AT        8'h40
`define MPG_PFX_HASH      8'h23
`define MPG_PFX_DOLLAR    8'h24
`define MPG_PFX_PCT       8'h25
`define MPG_PFX_AND       8'h26
`define MPG_ADDR_HI_RST   8'h30
`define MPG_ADDR_LO_RST   8'h31
`define MPG_ASCII_ZERO    8'h30
`define MPG_ASCII_NINE    8'h39
`define MPG_CHAR_Q        8'h51
`define MPG_CHAR_U        8'h55
`define MPG_CHAR_I        8'h49
`define MPG_CHAR_T        8'h54
`define MPG_CHAR_CR       8'h0D
`define MPG_CHAR_CAN      8'h18
`define MPG_CLK_HZ        50000000
`define MPG_SETTLE_RST    8'h01
`define MPG_TIMEOUT_RST   8'h3C
`define MPG_RESP_OKAY     2'b00
`define MPG_RESP_SLVERR   2'b10
`endif

// >>> verilog/mpg_pkg.sv
// Types for the multidrop port address gate
package mpg_pkg;
   typedef enum logic [1:0] {
      MPG_HUNT_PFX  = 2'b00,
      MPG_HUNT_HI   = 2'b01,
      MPG_HUNT_LO   = 2'b10,
      MPG_OPEN      = 2'b11
   } mpg_state_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } mpg_char_t;
endpackage : mpg_pkg

// >>> verilog/mpg_sec_timer.sv
// Seconds down-counter used for settle and idle time-outs
`timescale 1ns/10ps
module mpg_sec_timer #(
   parameter int TICKS_PER_SEC = 50000000
) (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       load,
   input  wire logic [7:0] seconds,
   output logic            expired
);
   logic [31:0] tick;
   logic [31:0] next_tick;
   logic [7:0]  secs;
   logic [7:0]  next_secs;
   always_comb begin
      next_tick = tick;
      next_secs = secs;
      if (load) begin
         next_tick = 32'(TICKS_PER_SEC - 1);
         next_secs = seconds;
      end else if (secs != 8'h00) begin
         if (tick == 32'h0000_0000) begin
            next_tick = 32'(TICKS_PER_SEC - 1);
            next_secs = secs - 8'h01;
         end else begin
            next_tick = tick - 32'h0000_0001;
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick <= 32'h0000_0000;
         secs <= 8'h00;
      end else begin
         tick <= next_tick;
         secs <= next_secs;
      end
   end
   assign expired = (secs == 8'h00) && !load;
endmodule : mpg_sec_timer

// >>> verilog/mpg_gate.sv
// Multidrop port address gate with AXI4-Lite settings
//
// How it works
// - Multidrop mode exposes prefix, address, settle settings
// - Prefix is one of @#$%&, default @
// - Address two decimal digits 01..99, default 01
// - Hold transmit for settle seconds after RTS
// - Idle port discards characters until prefix+address
// - Match enables echo and transmission
// - Open session passes normal command stream
// - Session_close_command command closes session, hunting resumes
// - Idle time-out closes session
// - Binary requests may interrupt ASCII output
// - Non-interleaving host served normally too
`include "mpg_cfg.svh"
`timescale 1ns/10ps
module mpg_gate
#(
   parameter int TICKS_PER_SEC = `MPG_CLK_HZ
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [5:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [5:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire mpg_pkg::mpg_char_t rx_char,
   input  wire mpg_pkg::mpg_char_t tx_char,
   output mpg_pkg::mpg_char_t    line_tx,
   output mpg_pkg::mpg_char_t    cmd_rx,
   output logic                  rts,
   output logic                  session_open
);
   import mpg_pkg::*;
   // Settings
   logic       multidrop_port_switch;
   logic [7:0] prefix;
   logic [7:0] addr_hi;
   logic [7:0] addr_lo;
   logic [7:0] transmit_settle_delay;
   logic [7:0] idle_timeout;
   logic       next_multidrop_port_switch;
   logic [7:0] next_prefix;
   logic [7:0] next_addr_hi;
   logic [7:0] next_addr_lo;
   logic [7:0] next_transmit_settle_delay;
   logic [7:0] next_idle_timeout;
   // Bus slave
   logic        aw_hold;
   logic        w_hold;
   logic [5:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        next_aw_hold;
   logic        next_w_hold;
   logic [5:0]  next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_rvalid;
   logic [1:0]  next_rresp;
   logic [31:0] next_rdata;
   logic        do_write;
   logic        wr_ok;
   // Gate state
   mpg_state_t state;
   mpg_state_t next_state;
   logic [2:0] session_close_command_pos;
   logic [2:0] next_session_close_command_pos;
   logic       session_close_command_seen;
   logic       next_session_close_command_seen;
   logic       next_rts;
   logic       settle_load;
   logic       idle_load;
   logic       settle_done;
   logic       idle_done;
   mpg_char_t  next_line_tx;
   mpg_char_t  next_cmd_rx;
   function automatic logic valid_prefix(input logic [7:0] c);
      valid_prefix = (c == `MPG_PFX_AT) || (c == `MPG_PFX_HASH) ||
                     (c == `MPG_PFX_DOLLAR) || (c == `MPG_PFX_PCT) ||
                     (c == `MPG_PFX_AND);
   endfunction : valid_prefix
   function automatic logic is_digit(input logic [7:0] c);
      is_digit = (c >= `MPG_ASCII_ZERO) && (c <= `MPG_ASCII_NINE);
   endfunction : is_digit
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   always_comb begin
      next_aw_hold = aw_hold;
      next_w_hold  = w_hold;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_hold = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_hold = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      do_write = aw_hold && w_hold;
      if (do_write) begin
         next_aw_hold = 1'b0;
         next_w_hold  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wr_ok ? `MPG_RESP_OKAY : `MPG_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
   end
   // Settings writes; illegal values are refused and keep the old setting
   always_comb begin
      next_multidrop_port_switch = multidrop_port_switch;
      next_prefix                = prefix;
      next_addr_hi               = addr_hi;
      next_addr_lo               = addr_lo;
      next_transmit_settle_delay = transmit_settle_delay;
      next_idle_timeout          = idle_timeout;
      wr_ok                      = 1'b1;
      if (aw_hold && w_hold && w_strb[0]) begin
         unique case (aw_addr)
            `MPG_OFF_CTRL: next_multidrop_port_switch = w_data[0];
            `MPG_OFF_ADDR: begin
               if (valid_prefix(w_data[23:16]) && is_digit(w_data[15:8]) &&
                   is_digit(w_data[7:0]) &&
                   !(w_data[15:8] == `MPG_ASCII_ZERO &&
                     w_data[7:0] == `MPG_ASCII_ZERO)) begin
                  next_prefix  = w_data[23:16];
                  next_addr_hi = w_data[15:8];
                  next_addr_lo = w_data[7:0];
               end else begin
                  wr_ok = 1'b0;
               end
            end
            `MPG_OFF_SETTLE:  next_transmit_settle_delay = w_data[7:0];
            `MPG_OFF_TIMEOUT: next_idle_timeout = w_data[7:0];
            default:          wr_ok = 1'b0;
         endcase
      end else if (aw_hold && w_hold) begin
         wr_ok = 1'b0;
      end
   end
   always_comb begin
      next_rvalid = s_axi_rvalid;
      next_rresp  = s_axi_rresp;
      next_rdata  = s_axi_rdata;
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = `MPG_RESP_OKAY;
         unique case (s_axi_araddr)
            `MPG_OFF_CTRL:    next_rdata = {31'h0000_0000, multidrop_port_switch};
            `MPG_OFF_ADDR:    next_rdata = {8'h00, prefix, addr_hi, addr_lo};
            `MPG_OFF_SETTLE:  next_rdata = {24'h00_0000, transmit_settle_delay};
            `MPG_OFF_TIMEOUT: next_rdata = {24'h00_0000, idle_timeout};
            `MPG_OFF_STATUS:  next_rdata = {28'h000_0000, rts, session_open, state};
            default: begin
               next_rdata = 32'h0000_0000;
               next_rresp = `MPG_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
   end
   // Address hunt, session, session_close_command detection
   always_comb begin
      next_state     = state;
      next_session_close_command_pos  = session_close_command_pos;
      next_session_close_command_seen = 1'b0;
      next_rts       = rts;
      next_cmd_rx    = '0;
      next_line_tx   = '0;
      settle_load    = 1'b0;
      idle_load      = 1'b0;
      if (!multidrop_port_switch) begin
         next_state  = MPG_OPEN; // Default protocol: port always live
         next_rts    = 1'b1;
         next_cmd_rx = rx_char;
         next_line_tx = tx_char;
      end else begin
         unique case (state)
            MPG_HUNT_PFX: begin
               next_rts = 1'b0;
               if (rx_char.valid && rx_char.data == prefix)
                  next_state = MPG_HUNT_HI;
            end
            MPG_HUNT_HI: begin
               if (rx_char.valid)
                  next_state = (rx_char.data == addr_hi) ? MPG_HUNT_LO : MPG_HUNT_PFX;
            end
            MPG_HUNT_LO: begin
               if (rx_char.valid) begin
                  if (rx_char.data == addr_lo) begin
                     next_state    = MPG_OPEN;
                     next_rts      = 1'b1;
                     next_session_close_command_pos = 3'd0;
                     settle_load   = 1'b1;
                     idle_load     = 1'b1;
                  end else begin
                     next_state = MPG_HUNT_PFX;
                  end
               end
            end
            MPG_OPEN: begin
               next_cmd_rx = rx_char;
               if (rx_char.valid) begin
                  idle_load = 1'b1;
                  if (settle_done)
                     next_line_tx = rx_char; // Echo
                  next_session_close_command_seen = (session_close_command_pos == 3'd4) && (rx_char.data == `MPG_CHAR_CR);
                  unique case (session_close_command_pos)
                     3'd0: next_session_close_command_pos = (rx_char.data == `MPG_CHAR_Q) ? 3'd1 : 3'd0;
                     3'd1: next_session_close_command_pos = (rx_char.data == `MPG_CHAR_U) ? 3'd2 : 3'd0;
                     3'd2: next_session_close_command_pos = (rx_char.data == `MPG_CHAR_I) ? 3'd3 : 3'd0;
                     3'd3: next_session_close_command_pos = (rx_char.data == `MPG_CHAR_T) ? 3'd4 : 3'd0;
                     default: next_session_close_command_pos = 3'd0;
                  endcase
               end else if (tx_char.valid && settle_done) begin
                  next_line_tx = tx_char;
               end
               if (session_close_command_seen || idle_done) begin
                  next_state = MPG_HUNT_PFX;
                  next_rts   = 1'b0;
               end
            end
         endcase
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         multidrop_port_switch <= 1'b0;
         prefix                <= `MPG_PFX_AT;
         addr_hi               <= `MPG_ADDR_HI_RST;
         addr_lo               <= `MPG_ADDR_LO_RST;
         transmit_settle_delay <= `MPG_SETTLE_RST;
         idle_timeout          <= `MPG_TIMEOUT_RST;
         aw_hold               <= 1'b0;
         w_hold                <= 1'b0;
         aw_addr               <= 6'h00;
         w_data                <= 32'h0000_0000;
         w_strb                <= 4'h0;
         s_axi_bvalid          <= 1'b0;
         s_axi_bresp           <= `MPG_RESP_OKAY;
         s_axi_rvalid          <= 1'b0;
         s_axi_rresp           <= `MPG_RESP_OKAY;
         s_axi_rdata           <= 32'h0000_0000;
         state                 <= MPG_HUNT_PFX;
         session_close_command_pos              <= 3'd0;
         session_close_command_seen             <= 1'b0;
         rts                   <= 1'b0;
         cmd_rx                <= '0;
         line_tx               <= '0;
      end else begin
         multidrop_port_switch <= next_multidrop_port_switch;
         prefix                <= next_prefix;
         addr_hi               <= next_addr_hi;
         addr_lo               <= next_addr_lo;
         transmit_settle_delay <= next_transmit_settle_delay;
         idle_timeout          <= next_idle_timeout;
         aw_hold               <= next_aw_hold;
         w_hold                <= next_w_hold;
         aw_addr               <= next_aw_addr;
         w_data                <= next_w_data;
         w_strb                <= next_w_strb;
         s_axi_bvalid          <= next_bvalid;
         s_axi_bresp           <= next_bresp;
         s_axi_rvalid          <= next_rvalid;
         s_axi_rresp           <= next_rresp;
         s_axi_rdata           <= next_rdata;
         state                 <= next_state;
         session_close_command_pos              <= next_session_close_command_pos;
         session_close_command_seen             <= next_session_close_command_seen;
         rts                   <= next_rts;
         cmd_rx                <= next_cmd_rx;
         line_tx               <= next_line_tx;
      end
   end
   assign session_open = (state == MPG_OPEN);
   mpg_sec_timer #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_settle (.aclk(aclk), .aresetn(aresetn),
      .load(settle_load), .seconds(transmit_settle_delay), .expired(settle_done));
   mpg_sec_timer #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_idle (.aclk(aclk), .aresetn(aresetn),
      .load(idle_load), .seconds(idle_timeout), .expired(idle_done));
   // Checks
   sequence s_match;
      state == MPG_HUNT_LO && rx_char.valid && rx_char.data == addr_lo;
   endsequence
   chk_hunt_discard: assert property (@(posedge aclk) disable iff (!aresetn)
      multidrop_port_switch && state != MPG_OPEN |=> !cmd_rx.valid)
      else $error("character passed while hunting");
   chk_match_opens: assert property (@(posedge aclk) disable iff (!aresetn)
      s_match and multidrop_port_switch ##0 1'b1 |=> session_open && rts)
      else $error("match did not open session");
   chk_settle_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      multidrop_port_switch && !settle_done |=> !line_tx.valid)
      else $error("transmit during settle");
   chk_session_close_command_close: assert property (@(posedge aclk) disable iff (!aresetn)
      multidrop_port_switch && session_open && session_close_command_seen |=> !session_open)
      else $error("session_close_command did not close");
   chk_idle_close: assert property (@(posedge aclk) disable iff (!aresetn)
      multidrop_port_switch && session_open && idle_done && !settle_load |=> !session_open)
      else $error("time-out did not close");
   chk_mismatch: assert property (@(posedge aclk) disable iff (!aresetn)
      multidrop_port_switch && state == MPG_HUNT_HI && rx_char.valid &&
      rx_char.data != addr_hi |=> state == MPG_HUNT_PFX)
      else $error("mismatch did not restart");
   chk_prefix_legal: assert property (@(posedge aclk) disable iff (!aresetn)
      valid_prefix(prefix))
      else $error("illegal prefix stored");
   chk_addr_legal: assert property (@(posedge aclk) disable iff (!aresetn)
      is_digit(addr_hi) && is_digit(addr_lo))
      else $error("illegal address stored");
   chk_pass_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
      session_open && multidrop_port_switch && rx_char.valid |=> cmd_rx.valid)
      else $error("command not passed");
endmodule : mpg_gate

// >>> test/mpg_host.sv
// Host terminal model driving received characters into the gate
`include "mpg_cfg.svh"
`timescale 1ns/10ps
module mpg_host
   import mpg_pkg::*;
#(
   parameter int GAP = 3
) (
   input  wire logic          aclk,
   output mpg_pkg::mpg_char_t rx_char
);
   import mpg_pkg::*;
   initial rx_char = '{1'b0, 8'h00};
   // Scaled character spacing for an 8N1 line at 2400 baud
   task automatic send(input logic [7:0] c);
      @(posedge aclk);
      rx_char <= '{1'b1, c};
      @(posedge aclk);
      rx_char <= '{1'b0, ~c};
      repeat (GAP) @(posedge aclk);
   endtask : send
   task automatic send_addr(input logic [7:0] p, input logic [15:0] a);
      send(p);
      send(a[15:8]);
      send(a[7:0]);
   endtask : send_addr
   task automatic send_session_close_command();
      send(`MPG_CHAR_Q);
      send(`MPG_CHAR_U);
      send(`MPG_CHAR_I);
      send(`MPG_CHAR_T);
      send(`MPG_CHAR_CR);
   endtask : send_session_close_command
   // Closes any session on the line before addressing
   task automatic send_cancel();
      send(`MPG_CHAR_CAN);
      send_session_close_command();
   endtask : send_cancel
   task automatic wait_prompt(input int n);
      repeat (n) @(posedge aclk);
   endtask : wait_prompt
endmodule : mpg_host

// >>> test/tb_top.sv
// Self-checking bench for the multidrop port address gate
`include "mpg_cfg.svh"
`timescale 1ns/10ps
module tb_top;
   import mpg_pkg::*;
   localparam int TPS = 10;
   typedef struct packed {
      logic        wr;
      logic [5:0]  a;
      logic [31:0] d;
      logic [1:0]  resp;
      logic [31:0] rd;
   } mpg_row_t;
   logic        aclk;
   logic        aresetn;
   logic [5:0]  awaddr;
   logic [5:0]  araddr;
   logic        awvalid;
   logic        wvalid;
   logic        bready;
   logic        arvalid;
   logic        rready;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0]  wstrb;
   logic        awready;
   logic        wready;
   logic        bvalid;
   logic        arready;
   logic        rvalid;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   mpg_char_t   rx_char;
   mpg_char_t   tx_char;
   mpg_char_t   line_tx;
   mpg_char_t   cmd_rx;
   logic        rts;
   logic        session_open;
   int          error_cnt = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          cmd_cnt = 0;
   int          line_cnt = 0;
   int          waited;
   logic [7:0]  last_cmd;
   logic [7:0]  last_line;
   logic [1:0]  r;
   logic [31:0] d;
   mpg_row_t    rows[13];
   logic [7:0]  pfx[5] = '{`MPG_PFX_AT, `MPG_PFX_HASH, `MPG_PFX_DOLLAR, `MPG_PFX_PCT,
                           `MPG_PFX_AND};
   logic [15:0] adr[5] = '{16'h3939, 16'h3130, 16'h3031, 16'h3535, 16'h3039};

   mpg_gate #(.TICKS_PER_SEC(TPS)) u_mpg_gate (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_char(rx_char),
      .tx_char(tx_char), .line_tx(line_tx), .cmd_rx(cmd_rx), .rts(rts),
      .session_open(session_open)
   );
   mpg_host u_mpg_host (.aclk(aclk), .rx_char(rx_char));

   initial aclk = 1'b0;
   always #10 aclk = ~aclk;

   always @(posedge aclk) begin
      cyc++;
      if (cmd_rx.valid === 1'b1) begin
         cmd_cnt++;
         last_cmd = cmd_rx.data;
      end
      if (line_tx.valid === 1'b1) begin
         line_cnt++;
         last_line = line_tx.data;
      end
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic axi_write(input logic [5:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw_hit;
      logic w_hit;
      logic b_hit;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         aw_hit = awvalid & awready;
         w_hit = wvalid & wready;
         b_hit = bvalid & bready;
         rs = bresp;
         @(posedge aclk);
         if (aw_hit) awvalid <= 1'b0;
         if (w_hit) wvalid <= 1'b0;
      end while (b_hit !== 1'b1);
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [5:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic ar_hit;
      logic r_hit;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         ar_hit = arvalid & arready;
         r_hit = rvalid & rready;
         v = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ar_hit) arvalid <= 1'b0;
      end while (r_hit !== 1'b1);
      rready <= 1'b0;
   endtask : axi_read

   task automatic pulse_tx(input logic [7:0] c);
      @(posedge aclk);
      tx_char <= '{1'b1, c};
      @(posedge aclk);
      tx_char <= '{1'b0, ~c};
      repeat (3) @(posedge aclk);
   endtask : pulse_tx

   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   initial begin
      aresetn = 1'b0;
      {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
      wdata = '0;
      wstrb = 4'hF;
      tx_char = '{1'b0, 8'h00};
      rows[0] = '{1'b0, `MPG_OFF_CTRL, 32'h0, `MPG_RESP_OKAY, 32'h0000_0000};
      rows[1] = '{1'b0, `MPG_OFF_ADDR, 32'h0, `MPG_RESP_OKAY, 32'h0040_3031};
      rows[2] = '{1'b0, `MPG_OFF_SETTLE, 32'h0, `MPG_RESP_OKAY, 32'h0000_0001};
      rows[3] = '{1'b0, `MPG_OFF_TIMEOUT, 32'h0, `MPG_RESP_OKAY, 32'h0000_003C};
      rows[4] = '{1'b0, `MPG_OFF_STATUS, 32'h0, `MPG_RESP_OKAY, 32'h0000_000F};
      rows[5] = '{1'b1, `MPG_OFF_ADDR, 32'h0041_3031, `MPG_RESP_SLVERR, 32'h0};
      rows[6] = '{1'b1, `MPG_OFF_ADDR, 32'h0040_3030, `MPG_RESP_SLVERR, 32'h0};
      rows[7] = '{1'b1, `MPG_OFF_ADDR, 32'h0040_393A, `MPG_RESP_SLVERR, 32'h0};
      rows[8] = '{1'b1, `MPG_OFF_RXDATA, 32'h0, `MPG_RESP_SLVERR, 32'h0};
      rows[9] = '{1'b0, `MPG_OFF_TXDATA, 32'h0, `MPG_RESP_SLVERR, 32'h0};
      rows[10] = '{1'b0, `MPG_OFF_ADDR, 32'h0, `MPG_RESP_OKAY, 32'h0040_3031};
      rows[11] = '{1'b1, `MPG_OFF_SETTLE, 32'h0000_0001, `MPG_RESP_OKAY, 32'h0};
      rows[12] = '{1'b0, `MPG_OFF_SETTLE, 32'h0, `MPG_RESP_OKAY, 32'h0000_0001};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) axi_write(rows[i].a, rows[i].d, r);
         else axi_read(rows[i].a, d, r);
         check(r, rows[i].resp);
         if (!rows[i].wr && rows[i].resp == `MPG_RESP_OKAY) check(d, rows[i].rd);
      end
      $display("register table done");
      u_mpg_host.send(8'h41);
      check(cmd_cnt, 1);
      axi_write(`MPG_OFF_CTRL, 32'h0000_0001, r);
      u_mpg_host.send_cancel();
      u_mpg_host.send_addr(`MPG_PFX_HASH, 16'h3031);
      u_mpg_host.send_addr(`MPG_PFX_AT, 16'h3040);
      u_mpg_host.send_addr(8'h30, 16'h3130);
      check(session_open, 0);
      check(cmd_cnt, 1);
      $display("hunt done");
      u_mpg_host.send_addr(`MPG_PFX_AT, 16'h3031);
      check({rts, session_open}, 2'b11);
      u_mpg_host.send(8'h53);
      check(cmd_cnt, 2);
      pulse_tx(8'h5A);
      check(line_cnt, 0);
      u_mpg_host.wait_prompt(3 * TPS);
      pulse_tx(8'h5A);
      check({line_cnt[7:0], last_line}, 16'h015A);
      u_mpg_host.send(8'hA5);
      check({last_cmd, last_line}, 16'hA5A5);
      u_mpg_host.send_session_close_command();
      check(session_open, 0);
      waited = cmd_cnt;
      pulse_tx(8'h5A);
      u_mpg_host.send(8'h58);
      check({line_cnt[7:0], cmd_cnt[7:0]}, {8'h07, waited[7:0]});
      $display("session done");
      for (int i = 0; i < 5; i++) begin
         axi_write(`MPG_OFF_ADDR, {8'h00, pfx[i], adr[i]}, r);
         axi_read(`MPG_OFF_ADDR, d, r);
         check(d, {8'h00, pfx[i], adr[i]});
         u_mpg_host.send_cancel();
         u_mpg_host.send_addr(pfx[i], adr[i]);
         check(session_open, 1);
         u_mpg_host.send_session_close_command();
         check(session_open, 0);
      end
      $display("prefix table done");
      axi_write(`MPG_OFF_TIMEOUT, 32'h0000_0002, r);
      u_mpg_host.send_addr(pfx[4], adr[4]);
      check(session_open, 1);
      waited = 0;
      while (session_open === 1'b1 && waited < 8 * TPS) begin
         @(posedge aclk);
         waited++;
      end
      check(session_open, 0);
      check(waited > TPS, 1);
      $display("idle time-out done");
      u_mpg_host.send_addr(pfx[4], adr[4]);
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      check({rts, session_open}, 2'b00);
      axi_read(`MPG_OFF_ADDR, d, r);
      check(d, 32'h0040_3031);
      $display("mid-run reset done");
      summarize();
   end
endmodule : tb_top
